// ---- src/coproc_host_port.sv ----
`timescale 1ns/100ps
// What this block does
// - decode 12-bit word address into unit selects
// - 32-bit two-way data bus, bit 0 msb
// - host selects device; no response without select
// - host drives direction high read, low write
// - host marks burst low in beat style
// - strobe style: transfer opens on strobe plus select
// - beat-valid input ignored in strobe style
// - host asserts beat valid per valid beat
// - strobe style: acknowledge low on completed access
// - beat style: same pin is high wait
// - asynchronous reset to known state
// - strap picks style, 1 beat, 0 strobe
// - endian strap high big, low little
// - interrupt low when any unmasked unit requests
// - unit requests ORed, maskable, not prioritised
module coproc_host_port (
    // clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_resetn,
    input  wire logic                         i_ce,
    // host pins
    host_bus_if.device                        bus,
    // write stream to the units
    output logic                              o_wr_valid,
    input  wire logic                         i_wr_ready,
    output logic [hbp_pkg::UNIT_N-1:0]        o_wr_sel,
    output logic [hbp_pkg::ADDR_W-1:0]        o_wr_addr,
    output logic [hbp_pkg::DATA_W-1:0]        o_wr_data,
    // read request and answer
    output logic                              o_rd_req,
    output logic [hbp_pkg::UNIT_N-1:0]        o_rd_sel,
    output logic [hbp_pkg::ADDR_W-1:0]        o_rd_addr,
    input  wire logic                         i_rd_valid,
    input  wire logic [hbp_pkg::DATA_W-1:0]   i_rd_data,
    // unit interrupts
    input  wire logic [hbp_pkg::UNIT_N-1:0]   i_unit_irq,
    input  wire logic [hbp_pkg::UNIT_N-1:0]   i_irq_mask
);
    typedef enum logic [2:0] {
        D_IDLE      = 3'b000,
        D_WRITE     = 3'b001,
        D_READ_REQ  = 3'b010,
        D_READ_WAIT = 3'b011,
        D_FINISH    = 3'b100
    } dev_state_t;

    dev_state_t                  state_reg;
    dev_state_t                  state_next;
    logic                        style_reg;
    logic                        style_next;
    logic                        big_reg;
    logic                        big_next;
    logic                        strap_done_reg;
    logic                        strap_done_next;
    logic                        rw_reg;
    logic                        rw_next;
    logic                        burst_reg;
    logic                        burst_next;
    logic [hbp_pkg::ADDR_W-1:0]  addr_reg;
    logic [hbp_pkg::ADDR_W-1:0]  addr_next;
    logic [hbp_pkg::ADDR_W-1:0]  take_addr;
    logic [hbp_pkg::UNIT_N-1:0]  sel_reg;
    logic [hbp_pkg::UNIT_N-1:0]  sel_next;
    logic [hbp_pkg::DATA_W-1:0]  wdata_reg;
    logic [hbp_pkg::DATA_W-1:0]  wdata_next;
    logic [hbp_pkg::DATA_W-1:0]  rdata_reg;
    logic [hbp_pkg::DATA_W-1:0]  rdata_next;
    logic                        pin_reg;
    logic                        pin_next;
    logic                        oe_reg;
    logic                        oe_next;
    logic                        irq_n_reg;
    logic                        irq_n_next;
    logic                        rd_req_reg;
    logic                        rd_req_next;
    logic                        push;
    logic                        wq_in_ready;
    logic [hbp_pkg::WQ_W-1:0]    wq_out;

    word_fifo #(
        .WIDTH (hbp_pkg::WQ_W),
        .DEPTH (hbp_pkg::FIFO_DEPTH)
    ) u_write_queue (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_ce        (i_ce),
        .i_in_valid  (push),
        .o_in_ready  (wq_in_ready),
        .i_in_data   ({sel_reg, addr_reg, wdata_reg}),
        .o_out_valid (o_wr_valid),
        .i_out_ready (i_wr_ready),
        .o_out_data  (wq_out)
    );

    assign o_wr_sel  = wq_out[hbp_pkg::WQ_W-1 -: hbp_pkg::UNIT_N];
    assign o_wr_addr = wq_out[hbp_pkg::DATA_W +: hbp_pkg::ADDR_W];
    assign o_wr_data = wq_out[hbp_pkg::DATA_W-1:0];
    assign o_rd_req  = rd_req_reg;
    assign o_rd_sel  = sel_reg;
    assign o_rd_addr = addr_reg;

    // pin order maps straight: bus bit 0 takes register bit 31
    assign bus.dev_data     = rdata_reg;
    assign bus.dev_data_oe  = oe_reg;
    assign bus.access_ack_n = pin_reg;
    assign bus.irq_n        = irq_n_reg;

    always_comb begin
        state_next      = state_reg;
        style_next      = style_reg;
        big_next        = big_reg;
        strap_done_next = strap_done_reg;
        rw_next         = rw_reg;
        burst_next      = burst_reg;
        addr_next       = addr_reg;
        sel_next        = sel_reg;
        wdata_next      = wdata_reg;
        rdata_next      = rdata_reg;
        rd_req_next     = 1'b0;
        push            = 1'b0;
        take_addr       = bus.addr;
        // straps are static; caught once, just after reset release
        if (!strap_done_reg) begin
            style_next      = bus.bus_style;
            big_next        = bus.big_endian;
            strap_done_next = 1'b1;
        end
        case (state_reg)
            D_IDLE: begin
                if (bus.chip_sel_n) begin
                    burst_next = 1'b0;
                end else if (strap_done_reg &&
                             (style_reg ? !bus.beat_valid_n
                                        : !bus.cycle_open_strobe_n)) begin
                    // later beats of a burst step the word address
                    if (style_reg && burst_reg) begin
                        take_addr = addr_reg + hbp_pkg::ADDR_W'(1);
                    end
                    addr_next  = take_addr;
                    sel_next   = hbp_pkg::unit_decode(take_addr);
                    rw_next    = bus.rd_wr;
                    burst_next = style_reg && !bus.burst_n;
                    wdata_next = hbp_pkg::byte_order(bus.data_bus,
                                                     big_reg);
                    state_next = bus.rd_wr ? D_READ_REQ : D_WRITE;
                end
            end
            D_WRITE: begin
                // a full queue stretches the cycle instead of losing data
                if (sel_reg == '0) begin
                    state_next = D_FINISH;
                end else if (wq_in_ready) begin
                    push       = 1'b1;
                    state_next = D_FINISH;
                end
            end
            D_READ_REQ: begin
                // reads wait for queued writes so they see them done
                if (sel_reg == '0) begin
                    rdata_next = '0;
                    state_next = D_FINISH;
                end else if (!o_wr_valid) begin
                    rd_req_next = 1'b1;
                    state_next  = D_READ_WAIT;
                end
            end
            D_READ_WAIT: begin
                if (i_rd_valid) begin
                    rdata_next = hbp_pkg::byte_order(i_rd_data,
                                                     big_reg);
                    state_next = D_FINISH;
                end
            end
            D_FINISH: begin
                state_next = D_IDLE;
            end
            default: begin
                state_next = D_IDLE;
            end
        endcase
        // strobe style: low one cycle at finish; beat style: high busy
        if (state_next == D_FINISH ||
            (style_reg && state_next == D_IDLE)) begin
            pin_next = hbp_pkg::PIN_LOW;
        end else begin
            pin_next = hbp_pkg::PIN_HIGH;
        end
        oe_next    = (state_next == D_FINISH) && rw_next;
        irq_n_next = ~|(i_unit_irq & ~i_irq_mask);
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg      <= D_IDLE;
            style_reg      <= hbp_pkg::STYLE_STROBE;
            big_reg        <= 1'b0;
            strap_done_reg <= 1'b0;
            rw_reg         <= 1'b0;
            burst_reg      <= 1'b0;
            addr_reg       <= '0;
            sel_reg        <= '0;
            wdata_reg      <= '0;
            rdata_reg      <= '0;
            pin_reg        <= hbp_pkg::PIN_HIGH;
            oe_reg         <= 1'b0;
            irq_n_reg      <= hbp_pkg::PIN_HIGH;
            rd_req_reg     <= 1'b0;
        end else if (i_ce) begin
            state_reg      <= state_next;
            style_reg      <= style_next;
            big_reg        <= big_next;
            strap_done_reg <= strap_done_next;
            rw_reg         <= rw_next;
            burst_reg      <= burst_next;
            addr_reg       <= addr_next;
            sel_reg        <= sel_next;
            wdata_reg      <= wdata_next;
            rdata_reg      <= rdata_next;
            pin_reg        <= pin_next;
            oe_reg         <= oe_next;
            irq_n_reg      <= irq_n_next;
            rd_req_reg     <= rd_req_next;
        end
    end
endmodule

// ---- src/hbp_pkg.sv ----
package hbp_pkg;
    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 32;
    localparam int UNIT_N     = 5;
    localparam int FIFO_DEPTH = 16;
    localparam int WQ_W       = UNIT_N + ADDR_W + DATA_W;

    // region code sits in the top three word-address bits
    localparam int REGION_LSB = 9;
    localparam int REGION_W   = 3;
    localparam logic [2:0] REGION_HASH   = 3'h0;
    localparam logic [2:0] REGION_BLOCK  = 3'h1;
    localparam logic [2:0] REGION_STREAM = 3'h2;
    localparam logic [2:0] REGION_BUFIF  = 3'h4;
    localparam logic [2:0] REGION_PUBKEY = 3'h5;

    localparam int UNIT_HASH   = 0;
    localparam int UNIT_BLOCK  = 1;
    localparam int UNIT_STREAM = 2;
    localparam int UNIT_BUFIF  = 3;
    localparam int UNIT_PUBKEY = 4;

    localparam logic STYLE_STROBE = 1'b0;
    localparam logic STYLE_BEAT   = 1'b1;
    localparam logic PIN_HIGH     = 1'b1;
    localparam logic PIN_LOW      = 1'b0;

    function automatic logic [UNIT_N-1:0] unit_decode(
        input logic [ADDR_W-1:0] a);
        logic [UNIT_N-1:0] s;
        s = '0;
        case (a[REGION_LSB +: REGION_W])
            REGION_HASH:   s[UNIT_HASH]   = 1'b1;
            REGION_BLOCK:  s[UNIT_BLOCK]  = 1'b1;
            REGION_STREAM: s[UNIT_STREAM] = 1'b1;
            REGION_BUFIF:  s[UNIT_BUFIF]  = 1'b1;
            REGION_PUBKEY: s[UNIT_PUBKEY] = 1'b1;
            default:       s = '0;
        endcase
        return s;
    endfunction

    function automatic logic [DATA_W-1:0] byte_order(
        input logic [DATA_W-1:0] d,
        input logic              big);
        return big ? d : {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction
endpackage

// ---- src/host_bus_if.sv ----
`timescale 1ns/100ps
interface host_bus_if;
    // data pins numbered 0..31, bit 0 is the msb
    logic [hbp_pkg::ADDR_W-1:0] addr;
    logic [0:hbp_pkg::DATA_W-1] host_data;
    logic                       host_data_oe;
    logic [0:hbp_pkg::DATA_W-1] dev_data;
    logic                       dev_data_oe;
    wire  [0:hbp_pkg::DATA_W-1] data_bus;
    logic                       chip_sel_n;
    logic                       rd_wr;
    logic                       burst_n;
    logic                       cycle_open_strobe_n;
    logic                       beat_valid_n;
    logic                       access_ack_n;
    logic                       irq_n;
    logic                       bus_style;
    logic                       big_endian;

    // released bus reads as zero; the two oes say who owns it
    assign data_bus = dev_data_oe  ? dev_data  :
                      host_data_oe ? host_data : '0;

    modport device (
        input  addr,
        input  data_bus,
        input  chip_sel_n,
        input  rd_wr,
        input  burst_n,
        input  cycle_open_strobe_n,
        input  beat_valid_n,
        input  bus_style,
        input  big_endian,
        output dev_data,
        output dev_data_oe,
        output access_ack_n,
        output irq_n
    );

    modport host (
        output addr,
        output host_data,
        output host_data_oe,
        output chip_sel_n,
        output rd_wr,
        output burst_n,
        output cycle_open_strobe_n,
        output beat_valid_n,
        input  data_bus,
        input  access_ack_n,
        input  irq_n,
        input  bus_style
    );
endinterface

// ---- src/word_fifo.sv ----
`timescale 1ns/100ps
// depth must be a power of two: pointers wrap by overflow
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_ce,
    // fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW-1:0]    rd_ptr_next;
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count_reg != CW'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data  = mem[rd_ptr_reg];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (push) begin
            wr_ptr_next = wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = rd_ptr_reg + 1'b1;
        end
        count_next = count_reg + CW'(push) - CW'(pop);
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (i_ce) begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end
endmodule

// ---- src/bus_host_end.sv ----
`timescale 1ns/100ps
module bus_host_end (
    // clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_resetn,
    input  wire logic                        i_ce,
    // device pins
    host_bus_if.host                         bus,
    // request side
    input  wire logic                        i_req_valid,
    input  wire logic                        i_req_rd,
    input  wire logic                        i_req_burst,
    input  wire logic [hbp_pkg::ADDR_W-1:0]  i_req_addr,
    input  wire logic [hbp_pkg::DATA_W-1:0]  i_req_wdata,
    output logic                             o_req_taken,
    // answer side
    output logic                             o_done,
    output logic [hbp_pkg::DATA_W-1:0]       o_rd_data,
    output logic                             o_busy
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_OPEN = 2'b01,
        H_WAIT = 2'b10
    } host_state_t;

    host_state_t                 state_reg;
    host_state_t                 state_next;
    logic                        cs_n_reg;
    logic                        cs_n_next;
    logic                        rw_reg;
    logic                        rw_next;
    logic                        ts_n_reg;
    logic                        ts_n_next;
    logic                        beat_n_reg;
    logic                        beat_n_next;
    logic                        burst_n_reg;
    logic                        burst_n_next;
    logic                        doe_reg;
    logic                        doe_next;
    logic [hbp_pkg::ADDR_W-1:0]  addr_reg;
    logic [hbp_pkg::ADDR_W-1:0]  addr_next;
    logic [hbp_pkg::DATA_W-1:0]  wdata_reg;
    logic [hbp_pkg::DATA_W-1:0]  wdata_next;
    logic [hbp_pkg::DATA_W-1:0]  rdata_reg;
    logic [hbp_pkg::DATA_W-1:0]  rdata_next;
    logic                        taken_reg;
    logic                        taken_next;
    logic                        done_reg;
    logic                        done_next;
    logic                        busy_reg;
    logic                        launch;
    logic                        beat_style;

    assign beat_style              = (bus.bus_style == hbp_pkg::STYLE_BEAT);
    assign bus.addr                = addr_reg;
    assign bus.host_data           = wdata_reg;
    assign bus.host_data_oe        = doe_reg;
    assign bus.chip_sel_n          = cs_n_reg;
    assign bus.rd_wr               = rw_reg;
    assign bus.burst_n             = burst_n_reg;
    assign bus.cycle_open_strobe_n = ts_n_reg;
    assign bus.beat_valid_n        = beat_n_reg;
    assign o_req_taken             = taken_reg;
    assign o_done                  = done_reg;
    assign o_rd_data               = rdata_reg;
    assign o_busy                  = busy_reg;

    always_comb begin
        state_next   = state_reg;
        cs_n_next    = cs_n_reg;
        rw_next      = rw_reg;
        ts_n_next    = ts_n_reg;
        beat_n_next  = beat_n_reg;
        burst_n_next = burst_n_reg;
        doe_next     = doe_reg;
        addr_next    = addr_reg;
        wdata_next   = wdata_reg;
        rdata_next   = rdata_reg;
        taken_next   = 1'b0;
        done_next    = 1'b0;
        launch       = 1'b0;
        case (state_reg)
            H_IDLE: begin
                launch = i_req_valid;
            end
            H_OPEN: begin
                // the strobe is one cycle; the answer pin is not yet valid
                ts_n_next  = hbp_pkg::PIN_HIGH;
                state_next = H_WAIT;
            end
            H_WAIT: begin
                // low means acknowledge, or wait released, in both styles
                if (!bus.access_ack_n) begin
                    done_next = 1'b1;
                    if (rw_reg) begin
                        rdata_next = bus.data_bus;
                    end
                    if (beat_style && !burst_n_reg &&
                        i_req_valid && i_req_burst) begin
                        launch = 1'b1;
                    end else begin
                        cs_n_next    = hbp_pkg::PIN_HIGH;
                        beat_n_next  = hbp_pkg::PIN_HIGH;
                        burst_n_next = hbp_pkg::PIN_HIGH;
                        doe_next     = 1'b0;
                        state_next   = H_IDLE;
                    end
                end
            end
            default: begin
                state_next = H_IDLE;
            end
        endcase
        if (launch) begin
            cs_n_next    = hbp_pkg::PIN_LOW;
            rw_next      = i_req_rd;
            addr_next    = i_req_addr;
            wdata_next   = i_req_wdata;
            doe_next     = !i_req_rd;
            ts_n_next    = beat_style;
            beat_n_next  = !beat_style;
            burst_n_next = !(beat_style && i_req_burst);
            taken_next   = 1'b1;
            state_next   = H_OPEN;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg   <= H_IDLE;
            cs_n_reg    <= hbp_pkg::PIN_HIGH;
            rw_reg      <= 1'b0;
            ts_n_reg    <= hbp_pkg::PIN_HIGH;
            beat_n_reg  <= hbp_pkg::PIN_HIGH;
            burst_n_reg <= hbp_pkg::PIN_HIGH;
            doe_reg     <= 1'b0;
            addr_reg    <= '0;
            wdata_reg   <= '0;
            rdata_reg   <= '0;
            taken_reg   <= 1'b0;
            done_reg    <= 1'b0;
            busy_reg    <= 1'b0;
        end else if (i_ce) begin
            state_reg   <= state_next;
            cs_n_reg    <= cs_n_next;
            rw_reg      <= rw_next;
            ts_n_reg    <= ts_n_next;
            beat_n_reg  <= beat_n_next;
            burst_n_reg <= burst_n_next;
            doe_reg     <= doe_next;
            addr_reg    <= addr_next;
            wdata_reg   <= wdata_next;
            rdata_reg   <= rdata_next;
            taken_reg   <= taken_next;
            done_reg    <= done_next;
            busy_reg    <= (state_next != H_IDLE);
        end
    end
endmodule

// ---- sim/host_port_sva.sv ----
`timescale 1ns/100ps
module host_port_sva (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // bus pins
    input wire logic chip_sel_n,
    input wire logic rd_wr,
    input wire logic cycle_open_strobe_n,
    input wire logic beat_valid_n,
    input wire logic burst_n,
    input wire logic access_ack_n,
    input wire logic dev_data_oe,
    input wire logic bus_style
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_beat_start;
        bus_style && $fell(beat_valid_n) && !chip_sel_n;
    endsequence
    sequence s_wait_then_free;
        access_ack_n ##[1:400] !access_ack_n;
    endsequence
    property p_ack_idle; !bus_style && chip_sel_n |-> access_ack_n; endproperty
    property p_ack_pulse; !bus_style && !access_ack_n |=> access_ack_n;
    endproperty
    property p_ack_sel;
        !bus_style && $fell(access_ack_n) |-> !$past(chip_sel_n);
    endproperty
    property p_strobe_ack;
        !bus_style && !cycle_open_strobe_n && !chip_sel_n
            |-> ##[2:400] !access_ack_n;
    endproperty
    property p_beat_wait; s_beat_start |=> s_wait_then_free; endproperty
    property p_oe_read; dev_data_oe |-> !chip_sel_n && rd_wr; endproperty
    property p_oe_one; dev_data_oe |=> !dev_data_oe; endproperty
    property p_beat_oe; bus_style && dev_data_oe |-> !access_ack_n; endproperty
    property p_burst_sel; !burst_n |-> bus_style && !chip_sel_n; endproperty
    a_ack_idle: assert property (p_ack_idle)
        else $error("ack pin low while not selected");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one clock");
    a_ack_sel: assert property (p_ack_sel)
        else $error("ack fell without select");
    a_strobe_ack: assert property (p_strobe_ack)
        else $error("strobe access never acknowledged");
    a_beat_wait: assert property (p_beat_wait)
        else $error("wait not held or never released");
    a_oe_read: assert property (p_oe_read)
        else $error("data driven outside selected read");
    a_oe_one: assert property (p_oe_one)
        else $error("data driven too long");
    a_beat_oe: assert property (p_beat_oe)
        else $error("wait high during read data");
    a_burst_sel: assert property (p_burst_sel)
        else $error("burst marked outside beat-style select");
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    logic        clk, resetn, wr_ready, rd_valid, rq_v, rq_rd, pexp, rs_q;
    logic        wr_valid, rd_req, taken, done, busy, rq_b;
    logic [31:0] rd_data, rq_d, wr_data, h_rdata;
    logic [11:0] rq_a, wr_addr, rd_addr;
    logic [4:0]  irq, mask, wr_sel, rd_sel;
    logic [48:0] exp_q[$];
    int          failures, n_tests, stall;
    host_bus_if hb();
    coproc_host_port i_coproc_host_port (.i_clk(clk), .i_resetn(resetn),
        .i_ce(1'b1), .bus(hb), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
        .o_wr_sel(wr_sel), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
        .o_rd_req(rd_req), .o_rd_sel(rd_sel), .o_rd_addr(rd_addr),
        .i_rd_valid(rd_valid), .i_rd_data(rd_data), .i_unit_irq(irq),
        .i_irq_mask(mask));
    bus_host_end i_bus_host_end (.i_clk(clk), .i_resetn(resetn),
        .i_ce(1'b1), .bus(hb), .i_req_valid(rq_v), .i_req_rd(rq_rd),
        .i_req_burst(rq_b), .i_req_addr(rq_a), .i_req_wdata(rq_d),
        .o_req_taken(taken), .o_done(done), .o_rd_data(h_rdata),
        .o_busy(busy));
    host_port_sva i_host_port_sva (.i_clk(clk), .i_resetn(resetn),
        .chip_sel_n(hb.chip_sel_n), .rd_wr(hb.rd_wr),
        .burst_n(hb.burst_n),
        .cycle_open_strobe_n(hb.cycle_open_strobe_n),
        .beat_valid_n(hb.beat_valid_n), .access_ack_n(hb.access_ack_n),
        .dev_data_oe(hb.dev_data_oe), .bus_style(hb.bus_style));
    function automatic logic [4:0] sel_of(input logic [11:0] a);
        case (a[11:9])
            3'h0: return 5'h01;
            3'h1: return 5'h02;
            3'h2: return 5'h04;
            3'h4: return 5'h08;
            3'h5: return 5'h10;
            default: return 5'h00;
        endcase
    endfunction
    function automatic logic [31:0] swap(input logic [31:0] d);
        return hb.big_endian ? d : {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction
    function automatic logic [31:0] rdfn(input logic [11:0] a);
        return {a, 8'ha5, a};
    endfunction
    task automatic check(input string what, input logic [48:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic op(input logic rd, input logic [11:0] a,
                      input logic [31:0] d);
        int k;
        if (!rd && sel_of(a) != 5'h00)
            exp_q.push_back({sel_of(a), a, swap(d)});
        @(posedge clk);
        #1 rq_v = 1'b1; rq_rd = rd; rq_a = a; rq_d = d; rq_b = 1'($urandom);
        k = 0;
        do begin @(posedge clk); k++; end while (taken !== 1'b1 && k < 500);
        check("busy", busy, 1'b1);
        #1 rq_v = 1'b0;
        while (done !== 1'b1 && k < 1000) begin @(posedge clk); k++; end
        if (k >= 1000) failures++;
        check("idle", busy, 1'b0);
        if (rd)
            check("rd_word", h_rdata,
                  (sel_of(a) != 5'h00) ? swap(rdfn(a)) : 32'h0000_0000);
    endtask
    initial begin clk = 1'b0; forever #10 clk = ~clk; end
    initial begin #400000 failures++; print_verdict; end
    // unit side: random drain, stall window to fill the fifo, random irqs
    always @(posedge clk) begin
        if (rs_q && resetn) check("irq_n", hb.irq_n, pexp);
        if (resetn && wr_valid && wr_ready)
            check("wr_word", {wr_sel, wr_addr, wr_data},
                  exp_q.size() ? exp_q.pop_front() : '1);
        pexp = ~|(irq & ~mask);
        rs_q = resetn;
        #1 wr_ready = (stall == 0) && ($urandom % 4 != 0);
        if (stall > 0) stall--;
        irq = 5'($urandom);
        mask = 5'($urandom);
    end
    always begin
        @(posedge clk);
        if (rd_req === 1'b1) begin
            check("rd_sel", rd_sel, sel_of(rd_addr));
            repeat ($urandom % 3) @(posedge clk);
            #1 rd_valid = 1'b1; rd_data = rdfn(rd_addr);
            @(posedge clk);
            #1 rd_valid = 1'b0;
        end
    end
    initial begin
        logic [11:0] a;
        failures = 0; n_tests = 0; stall = 0; rs_q = 0; pexp = 1'b1;
        resetn = 1'b0; wr_ready = 0; rd_valid = 0; rd_data = 0; rq_v = 0;
        rq_rd = 0; rq_a = 0; rq_d = 0; irq = 0; mask = 0; rq_b = 0;
        hb.bus_style = 1'b0; hb.big_endian = 1'b1;
        void'($urandom(32'h1844_df2f));
        for (int p = 0; p < 4; p++) begin
            @(posedge clk);
            #1 resetn = 1'b0; hb.bus_style = p[0]; hb.big_endian = p[1];
            repeat (8) @(posedge clk);
            check("reset_pins", {hb.access_ack_n, hb.dev_data_oe,
                  hb.irq_n, hb.chip_sel_n}, 4'b1011);
            #1 resetn = 1'b1; stall = 150;
            repeat (3) @(posedge clk);
            for (int i = 0; i < 40; i++) begin
                a = 12'($urandom);
                // fifo fills during the stall window before any read blocks
                if (i < 20) a[11:9] = 3'h1;
                op(i >= 20 && $urandom % 2, a, $urandom);
            end
            repeat (200) @(posedge clk);
            check("drained", exp_q.size(), 0);
            $display("test style %0d endian %0d done", p[0], p[1]);
        end
        print_verdict;
    end
endmodule
